// >>> src/lps_cfg.svh
/*
 * Constants of the link Phy_link_settings block: field positions, reset values,
 * lane and speed codes, and the sequence count scaling.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef LPS_CFG_SVH
`define LPS_CFG_SVH

// register selectors carried by a control command
`define LPS_SEL_GENERIC 1'b0
`define LPS_SEL_PHY 1'b1

// generic link settings layout
`define LPS_CC_BIT 63
`define LPS_LANE_HI 11
`define LPS_LANE_LO 8
`define LPS_PWR_BIT 0
`define LPS_CC_RESET 1'b0
`define LPS_LANE_RESET 4'h0
`define LPS_PWR_RESET 1'b0

// lane configuration codes
`define LPS_LANE_TWO 4'h0
`define LPS_LANE_2D1U 4'h2
`define LPS_LANE_1D2U 4'h3
`define LPS_LANE_2D2U 4'h4

// phy link settings layout
`define LPS_TURN_HI 39
`define LPS_TURN_LO 36
`define LPS_ALIGN_HI 35
`define LPS_ALIGN_LO 32
`define LPS_SPEED_HI 7
`define LPS_SPEED_LO 6
`define LPS_TURN_RESET 4'h0
`define LPS_ALIGN_RESET 4'h0
`define LPS_SPEED_RESET 2'h0

// speed range codes and reference-to-lane ratios
`define LPS_SPEED_A 2'h0
`define LPS_SPEED_B 2'h1
`define LPS_RATIO_A 5'h0f
`define LPS_RATIO_B 5'h1e

// sequence count scaling: turnaround in eights, alignment in fours, zero code means 16 units
`define LPS_TURN_UNIT_SHIFT 3
`define LPS_ALIGN_UNIT_SHIFT 2
`define LPS_TURN_ZERO_CNT 8'h80
`define LPS_ALIGN_ZERO_CNT 7'h40

// link events crossing from the link clock: index into the event vector
`define LPS_EVT_BOOT_SYNC 0
`define LPS_EVT_DORM_ENTER 1
`define LPS_EVT_DORM_EXIT 2
`define LPS_EVT_BOOT_DONE 3
`define LPS_EVT_COUNT 4

`endif

// >>> src/lps_pkg.sv
/*
 * Types of the link Phy_link_settings block: link state machine states,
 * control command carrier and the core state record.
 * Assumes lps_cfg.svh is on the include path.
 */
`include "lps_cfg.svh"

package lps_pkg;

    typedef enum logic [1:0] {
        LPS_CONFIG = 2'b00,
        LPS_ACTIVE = 2'b01,
        LPS_DORMANT = 2'b10
    } lps_lsm_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic broadcast;
        logic sel;
        logic [63:0] wdata;
    } lps_cmd_t;

    typedef struct packed {
        lps_lsm_t lsm;
        logic resume_active;
        logic boot_mode;
        logic cc;
        logic cc_pending;
        logic cc_pend_val;
        logic [3:0] lanes;
        logic [3:0] lanes_eff;
        logic pwr;
        logic pwr_eff;
        logic [3:0] turn_code;
        logic [3:0] align_code;
        logic [7:0] turn_cnt;
        logic [6:0] align_cnt;
        logic [1:0] speed;
        logic [1:0] speed_eff;
        logic [4:0] ratio;
        logic [63:0] rdata;
        logic rvalid;
    } lps_state_t;

endpackage : lps_pkg

// >>> src/lps_evt_cross.sv
/*
 * One link event crossing: a pulse on the link clock flips a toggle there, and the
 * core clock turns each toggle change into a one-cycle pulse.
 * Assumes link pulses are at least three core cycles apart.
 */
`timescale 1ns/100ps
`default_nettype none

module lps_evt_cross (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_link_clk,
    input wire logic i_link_evt,
    output logic o_evt
);

    logic toggle_reg;
    logic [2:0] sync_reg;

    // link side: the only flop written on the link clock
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            toggle_reg <= 1'b0;
        end else begin
            toggle_reg <= toggle_reg ^ i_link_evt;
        end
    end

    // first stage is read only by the second; edge taken between stages two and three
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_reg <= 3'h0;
            o_evt <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], toggle_reg};
            o_evt <= sync_reg[2] ^ sync_reg[1];
        end
    end

endmodule : lps_evt_cross

`default_nettype wire

// >>> src/lps_settings_regs.sv
/*
 * Generic and PHY link settings registers with the link state machine they steer.
 * Control commands arrive on the core clock; link events arrive on the link clock
 * and cross through lps_evt_cross. Effective settings leave on the core clock.
 * Assumes the command source honours the writable states of each field.
 */
// Function
// - clearing it in Active returns to Config after boot loading only
// - Config writes act at once; Active writes act after leaving Dormant, or at once during boot loading
// - boot sync sets config-complete and enters Active; host clears it later
// - lane field bits 11-8 resets to zero; codes 0,2,3,4 valid, others reserved
// - lanes writable in Config only; apply after Dormant; two lanes need no Dormant
// - each three-lane mode is refused unless that mode itself is supported
// - bit 0 picks logical idle fill or low power fill in Active
// - turnaround count bits 39-36 in eights, zero means 128
// - both counts written only in Config and take effect in Active
// - speed bits 7-6 reset range A, 01 range B; apply after leaving Dormant
// - both speed ranges supported across the 26 to 52 MHz reference span
// - selected phy revision bits 5-4 are reserved and carry no function
// - range A ratio 1:15, range B ratio 1:30 to the reference clock
`timescale 1ns/100ps
`default_nettype none
`include "lps_cfg.svh"

module lps_settings_regs
    import lps_pkg::*;
#(
    parameter bit SUPPORT_2D1U = 1'b1,
    parameter bit SUPPORT_1D2U = 1'b1,
    parameter bit SUPPORT_2D2U = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_link_clk,
    input wire lps_cmd_t i_cmd,
    input wire logic i_link_boot_sync,
    input wire logic i_link_dormant_enter,
    input wire logic i_link_dormant_exit,
    input wire logic i_link_boot_done,
    output logic [63:0] o_rdata,
    output logic o_rvalid,
    output lps_lsm_t o_link_state,
    output logic o_boot_mode,
    output logic [3:0] o_lanes,
    output logic o_low_power_fill,
    output logic [7:0] o_min_turnaround_count,
    output logic [6:0] o_min_alignment_count,
    output logic [1:0] o_speed_range,
    output logic [4:0] o_lane_ratio
);

    lps_state_t state_reg;
    lps_state_t state_next;
    logic [`LPS_EVT_COUNT-1:0] link_evt;
    logic [`LPS_EVT_COUNT-1:0] evt;

    assign link_evt = {i_link_boot_done, i_link_dormant_exit, i_link_dormant_enter,
                       i_link_boot_sync};

    generate
        for (genvar g = 0; g < `LPS_EVT_COUNT; g++) begin : g_evt
            lps_evt_cross u_cross (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_link_clk(i_link_clk),
                .i_link_evt(link_evt[g]),
                .o_evt(evt[g])
            );
        end
    endgenerate

    function automatic logic lane_ok(input logic [3:0] code);
        logic ok;
        ok = 1'b0;
        case (code)
            `LPS_LANE_TWO: ok = 1'b1;
            `LPS_LANE_2D1U: ok = SUPPORT_2D1U;
            `LPS_LANE_1D2U: ok = SUPPORT_1D2U;
            `LPS_LANE_2D2U: ok = SUPPORT_2D2U;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : lane_ok

    function automatic logic [7:0] turn_count(input logic [3:0] code);
        logic [7:0] n;
        n = {4'h0, code} << `LPS_TURN_UNIT_SHIFT;
        if (code == 4'h0) begin
            n = `LPS_TURN_ZERO_CNT;
        end
        return n;
    endfunction : turn_count

    function automatic logic [6:0] align_count(input logic [3:0] code);
        logic [6:0] n;
        n = {3'h0, code} << `LPS_ALIGN_UNIT_SHIFT;
        if (code == 4'h0) begin
            n = `LPS_ALIGN_ZERO_CNT;
        end
        return n;
    endfunction : align_count

    function automatic logic [4:0] speed_ratio(input logic [1:0] code);
        // the device runs either range from any reference in the span
        return (code == `LPS_SPEED_B) ? `LPS_RATIO_B : `LPS_RATIO_A;
    endfunction : speed_ratio

    always_comb begin
        logic wr_gen;
        logic wr_phy;
        logic rd;
        logic speed_ok;
        logic [63:0] gen_view;
        logic [63:0] phy_view;
        logic [3:0] new_lanes;
        logic [1:0] new_speed;

        state_next = state_reg;
        state_next.rvalid = 1'b0;
        wr_gen = i_cmd.valid && i_cmd.write && (i_cmd.sel == `LPS_SEL_GENERIC);
        wr_phy = i_cmd.valid && i_cmd.write && (i_cmd.sel == `LPS_SEL_PHY);
        rd = i_cmd.valid && !i_cmd.write;
        new_lanes = i_cmd.wdata[`LPS_LANE_HI:`LPS_LANE_LO];
        new_speed = i_cmd.wdata[`LPS_SPEED_HI:`LPS_SPEED_LO];
        speed_ok = (new_speed == `LPS_SPEED_A) || (new_speed == `LPS_SPEED_B);

        // register views: every bit not named below reads zero
        gen_view = 64'h0;
        gen_view[`LPS_CC_BIT] = state_reg.cc;
        gen_view[`LPS_LANE_HI:`LPS_LANE_LO] = state_reg.lanes;
        gen_view[`LPS_PWR_BIT] = state_reg.pwr;
        phy_view = 64'h0;
        phy_view[`LPS_TURN_HI:`LPS_TURN_LO] = state_reg.turn_code;
        phy_view[`LPS_ALIGN_HI:`LPS_ALIGN_LO] = state_reg.align_code;
        phy_view[`LPS_SPEED_HI:`LPS_SPEED_LO] = state_reg.speed;

        if (rd) begin
            state_next.rdata = (i_cmd.sel == `LPS_SEL_PHY) ? phy_view : gen_view;
            state_next.rvalid = 1'b1;
        end

        // link state machine; the broadcast flag is accepted either way on the device side
        // writes are dropped in Dormant; a dormant entry in the same cycle sets the state, but the write's fields still update
        case (state_reg.lsm)
            LPS_CONFIG: begin
                if (wr_gen) begin
                    state_next.cc = i_cmd.wdata[`LPS_CC_BIT];
                    if (i_cmd.wdata[`LPS_CC_BIT]) begin
                        state_next.lsm = LPS_ACTIVE;
                        // counts and fill mode take hold on entering Active
                        state_next.turn_cnt = turn_count(state_reg.turn_code);
                        state_next.align_cnt = align_count(state_reg.align_code);
                        // the fill bit carried by this same write is the one that applies
                        state_next.pwr_eff = i_cmd.wdata[`LPS_PWR_BIT];
                    end
                    if (lane_ok(new_lanes)) begin
                        state_next.lanes = new_lanes;
                        if (new_lanes == `LPS_LANE_TWO) begin
                            state_next.lanes_eff = new_lanes;
                        end
                    end
                    state_next.pwr = i_cmd.wdata[`LPS_PWR_BIT];
                end
                if (wr_phy) begin
                    state_next.turn_code = i_cmd.wdata[`LPS_TURN_HI:`LPS_TURN_LO];
                    state_next.align_code = i_cmd.wdata[`LPS_ALIGN_HI:`LPS_ALIGN_LO];
                    if (speed_ok) begin
                        state_next.speed = new_speed;
                    end
                end
                if (evt[`LPS_EVT_DORM_ENTER]) begin
                    state_next.lsm = LPS_DORMANT;
                    state_next.resume_active = 1'b0;
                end
            end
            LPS_ACTIVE: begin
                if (wr_gen && state_reg.boot_mode) begin
                    state_next.cc = i_cmd.wdata[`LPS_CC_BIT];
                end else if (wr_gen) begin
                    // held until the device next leaves Dormant
                    state_next.cc_pending = 1'b1;
                    state_next.cc_pend_val = i_cmd.wdata[`LPS_CC_BIT];
                end
                if (wr_phy && speed_ok) begin
                    state_next.speed = new_speed;
                end
                // boot loading done: a cleared bit sends the link back to Config
                if (evt[`LPS_EVT_BOOT_DONE] && state_reg.boot_mode) begin
                    state_next.boot_mode = 1'b0;
                    if (!state_next.cc) begin
                        state_next.lsm = LPS_CONFIG;
                    end
                end
                if (evt[`LPS_EVT_DORM_ENTER]) begin
                    state_next.lsm = LPS_DORMANT;
                    state_next.resume_active = 1'b1;
                end
            end
            LPS_DORMANT: begin
                if (evt[`LPS_EVT_DORM_EXIT]) begin
                    state_next.lsm = state_reg.resume_active ? LPS_ACTIVE : LPS_CONFIG;
                    state_next.lanes_eff = state_reg.lanes;
                    state_next.speed_eff = state_reg.speed;
                    state_next.ratio = speed_ratio(state_reg.speed);
                    if (state_reg.cc_pending) begin
                        // outside boot loading a cleared bit never leaves Active
                        state_next.cc = state_reg.cc_pend_val;
                        state_next.cc_pending = 1'b0;
                    end
                end
            end
            default: begin
                // unused code: fall back to Config rather than hang
                state_next.lsm = LPS_CONFIG;
            end
        endcase

        // boot sync overrides the state, config-complete, lane, fill and count updates this cycle
        if (evt[`LPS_EVT_BOOT_SYNC]) begin
            state_next.cc = 1'b1;
            state_next.boot_mode = 1'b1;
            state_next.lsm = LPS_ACTIVE;
            state_next.lanes = `LPS_LANE_TWO;
            state_next.lanes_eff = `LPS_LANE_TWO;
            state_next.cc_pending = 1'b0;
            state_next.pwr_eff = state_reg.pwr;
            state_next.turn_cnt = turn_count(state_reg.turn_code);
            state_next.align_cnt = align_count(state_reg.align_code);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg.lsm <= LPS_CONFIG;
            state_reg.resume_active <= 1'b0;
            state_reg.boot_mode <= 1'b0;
            state_reg.cc <= `LPS_CC_RESET;
            state_reg.cc_pending <= 1'b0;
            state_reg.cc_pend_val <= 1'b0;
            state_reg.lanes <= `LPS_LANE_RESET;
            state_reg.lanes_eff <= `LPS_LANE_RESET;
            state_reg.pwr <= `LPS_PWR_RESET;
            state_reg.pwr_eff <= `LPS_PWR_RESET;
            state_reg.turn_code <= `LPS_TURN_RESET;
            state_reg.align_code <= `LPS_ALIGN_RESET;
            state_reg.turn_cnt <= `LPS_TURN_ZERO_CNT;
            state_reg.align_cnt <= `LPS_ALIGN_ZERO_CNT;
            state_reg.speed <= `LPS_SPEED_RESET;
            state_reg.speed_eff <= `LPS_SPEED_RESET;
            state_reg.ratio <= `LPS_RATIO_A;
            state_reg.rdata <= 64'h0;
            state_reg.rvalid <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_rdata = state_reg.rdata;
    assign o_rvalid = state_reg.rvalid;
    assign o_link_state = state_reg.lsm;
    assign o_boot_mode = state_reg.boot_mode;
    assign o_lanes = state_reg.lanes_eff;
    assign o_low_power_fill = state_reg.pwr_eff;
    assign o_min_turnaround_count = state_reg.turn_cnt;
    assign o_min_alignment_count = state_reg.align_cnt;
    assign o_speed_range = state_reg.speed_eff;
    assign o_lane_ratio = state_reg.ratio;

endmodule : lps_settings_regs

`default_nettype wire

// >>> dv/lps_settings_regs_sva.sv
/*
 * Checker for the link settings register block, watching its top-level ports.
 * Assumes a single core clock domain and the active-low asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none
`include "lps_cfg.svh"

module lps_settings_regs_sva
    import lps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire lps_cmd_t i_cmd,
    input wire logic [63:0] o_rdata,
    input wire logic o_rvalid,
    input wire lps_lsm_t o_link_state,
    input wire logic o_boot_mode,
    input wire logic [3:0] o_lanes,
    input wire logic [7:0] o_min_turnaround_count,
    input wire logic [6:0] o_min_alignment_count,
    input wire logic [1:0] o_speed_range,
    input wire logic [4:0] o_lane_ratio
);
    // implemented bits of each register; everything else must read zero
    localparam logic [63:0] GEN_MASK = 64'h8000_0000_0000_0f01;
    localparam logic [63:0] PHY_MASK = 64'h0000_00ff_0000_00c0;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    chk_read_answer: assert property (
        i_cmd.valid && !i_cmd.write |=> o_rvalid) else $error("read not answered");
    chk_rsvd_read: assert property (
        o_rvalid |-> (o_rdata & ~($past(i_cmd.sel) ? PHY_MASK : GEN_MASK)) == 64'h0)
        else $error("reserved bits read nonzero");
    chk_cc_active: assert property (
        i_cmd.valid && i_cmd.write && i_cmd.sel == `LPS_SEL_GENERIC && i_cmd.wdata[63]
        && o_link_state == LPS_CONFIG |=> o_link_state == LPS_ACTIVE)
        else $error("config complete did not enter active");
    chk_lanes_legal: assert property (
        o_lanes inside {4'h0, 4'h2, 4'h3, 4'h4}) else $error("reserved lane code applied");
    chk_speed_legal: assert property (
        o_speed_range <= 2'h1) else $error("reserved speed code applied");
    chk_ratio_map: assert property (
        o_lane_ratio == ((o_speed_range == `LPS_SPEED_B) ? 5'h1e : 5'h0f))
        else $error("lane ratio does not follow speed range");
    chk_turn_units: assert property (
        o_min_turnaround_count[2:0] == 3'h0 && o_min_turnaround_count != 8'h0)
        else $error("turnaround count not in eights");
    chk_align_units: assert property (
        o_min_alignment_count[1:0] == 2'h0 && o_min_alignment_count != 7'h0)
        else $error("alignment count not in fours");
    chk_dormant_freeze: assert property (
        o_link_state == LPS_DORMANT |-> $stable(o_lanes)) else $error("lanes moved in dormant");

    cover property (o_boot_mode);
    cover property (o_link_state == LPS_DORMANT);
    cover property (o_rvalid && o_rdata[63]);
endmodule : lps_settings_regs_sva

`default_nettype wire

// >>> dv/lps_link_model.sv
/*
 * Link side model: raises one-link-cycle event pulses on the link clock.
 * Assumes the bench calls pulse() and spaces events well apart.
 */
`timescale 1ns/100ps
`default_nettype none
`include "lps_cfg.svh"

module lps_link_model (
    input wire logic i_link_clk,
    output logic [`LPS_EVT_COUNT-1:0] o_evt
);
    initial o_evt = '0;

    // launched after a link edge so the design samples it on the next one
    task automatic pulse(input int idx);
        @(posedge i_link_clk);
        o_evt[idx] <= 1'b1;
        @(posedge i_link_clk);
        o_evt <= '0;
    endtask : pulse
endmodule : lps_link_model

`default_nettype wire

// >>> dv/link_phy_settings_regs_tb.sv
/*
 * Self-checking bench of the link settings registers: command reads and writes,
 * link events through the link model, and a second reset for the boot path.
 * Assumes the package, header, design and checker are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none
`include "lps_cfg.svh"

module link_phy_settings_regs_tb;
    import lps_pkg::*;
    logic i_clk = 1'b0;
    logic i_link_clk = 1'b0;
    logic i_rst_n = 1'b0;
    lps_cmd_t cmd = '0;
    logic [`LPS_EVT_COUNT-1:0] evt;
    logic [63:0] rdata;
    logic rvalid;
    lps_lsm_t state;
    logic boot;
    logic [3:0] lanes;
    logic lowp;
    logic [7:0] turn;
    logic [6:0] align;
    logic [1:0] speed;
    logic [4:0] ratio;
    logic rv_seen;
    int error_cnt = 0;
    int check_count = 0;
    logic [3:0] bad_lanes [4] = '{4'h1, 4'h3, 4'h5, 4'hf};

    always #5 i_clk = ~i_clk;
    // offset keeps the link edges clear of the core edges
    initial begin
        #3.3;
        forever #62.5 i_link_clk = ~i_link_clk;
    end

    lps_settings_regs #(.SUPPORT_1D2U(1'b0)) u_lps_settings_regs (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_link_clk(i_link_clk), .i_cmd(cmd),
        .i_link_boot_sync(evt[`LPS_EVT_BOOT_SYNC]),
        .i_link_dormant_enter(evt[`LPS_EVT_DORM_ENTER]),
        .i_link_dormant_exit(evt[`LPS_EVT_DORM_EXIT]),
        .i_link_boot_done(evt[`LPS_EVT_BOOT_DONE]),
        .o_rdata(rdata), .o_rvalid(rvalid), .o_link_state(state), .o_boot_mode(boot),
        .o_lanes(lanes), .o_low_power_fill(lowp), .o_min_turnaround_count(turn),
        .o_min_alignment_count(align), .o_speed_range(speed), .o_lane_ratio(ratio));

    lps_link_model u_lps_link_model (.i_link_clk(i_link_clk), .o_evt(evt));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic do_reset();
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_link_clk);
        @(posedge i_clk);
        #1;
    endtask : do_reset

    // always broadcast, as a ring host must
    task automatic cmd_op(input logic wr, input logic sel, input logic [63:0] d);
        @(posedge i_clk);
        cmd <= '{1'b1, wr, 1'b1, sel, d};
        @(posedge i_clk);
        cmd.valid <= 1'b0;
        // the read pulse stands for this one cycle only
        #1;
        rv_seen = rvalid;
        @(posedge i_clk);
        #1;
    endtask : cmd_op

    task automatic rd(input logic sel, input logic [63:0] exp);
        cmd_op(1'b0, sel, 64'h0);
        check(rv_seen, 1'b1);
        check(rdata, exp);
    endtask : rd

    task automatic go(input int idx, input lps_lsm_t s);
        int n;
        n = 0;
        u_lps_link_model.pulse(idx);
        while (state !== s && n < 60) begin
            @(posedge i_clk);
            #1;
            n++;
        end
    endtask : go

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        do_reset();
        check(state, LPS_CONFIG);
        check({turn, align}, {8'h80, 7'h40});
        check({speed, ratio, lanes, lowp}, {2'h0, 5'h0f, 4'h0, 1'b0});
        rd(`LPS_SEL_GENERIC, 64'h0);
        rd(`LPS_SEL_PHY, 64'h0);
        $display("test reset done");
        cmd_op(1'b1, `LPS_SEL_PHY, 64'hffff_ff23_ffff_ff7f);
        rd(`LPS_SEL_PHY, 64'h0000_0023_0000_0040);
        check(speed, 2'h0);
        cmd_op(1'b1, `LPS_SEL_GENERIC, 64'h7fff_ffff_ffff_f2ff);
        rd(`LPS_SEL_GENERIC, 64'h0000_0000_0000_0201);
        check(lanes, 4'h0);
        foreach (bad_lanes[i]) begin
            cmd_op(1'b1, `LPS_SEL_GENERIC, {52'h0, bad_lanes[i], 8'h00});
            rd(`LPS_SEL_GENERIC, 64'h0000_0000_0000_0200);
        end
        $display("test config writes done");
        cmd_op(1'b1, `LPS_SEL_GENERIC, 64'h8000_0000_0000_0201);
        check(state, LPS_ACTIVE);
        check({lowp, turn, align}, {1'b1, 8'h10, 7'h0c});
        cmd_op(1'b1, `LPS_SEL_PHY, 64'h0000_0055_0000_00c0);
        rd(`LPS_SEL_PHY, 64'h0000_0023_0000_0040);
        cmd_op(1'b1, `LPS_SEL_GENERIC, 64'h0000_0000_0000_0201);
        check(state, LPS_ACTIVE);
        rd(`LPS_SEL_GENERIC, 64'h8000_0000_0000_0201);
        $display("test active writes done");
        go(`LPS_EVT_DORM_ENTER, LPS_DORMANT);
        check(state, LPS_DORMANT);
        check({lanes, speed}, {4'h0, 2'h0});
        go(`LPS_EVT_DORM_EXIT, LPS_ACTIVE);
        check(state, LPS_ACTIVE);
        check({lanes, speed, ratio}, {4'h2, 2'h1, 5'h1e});
        rd(`LPS_SEL_GENERIC, 64'h0000_0000_0000_0201);
        $display("test dormant done");
        do_reset();
        check(state, LPS_CONFIG);
        check({lanes, speed, ratio}, {4'h0, 2'h0, 5'h0f});
        go(`LPS_EVT_BOOT_SYNC, LPS_ACTIVE);
        check({state, boot, lanes}, {LPS_ACTIVE, 1'b1, 4'h0});
        rd(`LPS_SEL_GENERIC, 64'h8000_0000_0000_0000);
        cmd_op(1'b1, `LPS_SEL_GENERIC, 64'h0);
        check(state, LPS_ACTIVE);
        go(`LPS_EVT_BOOT_DONE, LPS_CONFIG);
        check(state, LPS_CONFIG);
        $display("test boot done");
        end_of_test();
    end
endmodule : link_phy_settings_regs_tb

bind lps_settings_regs lps_settings_regs_sva u_lps_settings_regs_sva (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd(i_cmd), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_link_state(o_link_state), .o_boot_mode(o_boot_mode),
    .o_lanes(o_lanes), .o_min_turnaround_count(o_min_turnaround_count),
    .o_min_alignment_count(o_min_alignment_count), .o_speed_range(o_speed_range),
    .o_lane_ratio(o_lane_ratio));

`default_nettype wire
